// ==== hw/ebic_ctrl.sv ====
// external bus idle-cycle and standby pin controller with wishbone register slave
`timescale 1ns/1ns
`include "ebic_params.svh"
module ebic_ctrl
    import ebic_pkg::*;
#(
    parameter int NUM_AREAS = `EBIC_NUM_AREAS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic acc_valid_i,
    input wire ebic_acc_t acc_i,
    output logic acc_done_o,
    input wire logic standby_i,
    input wire logic byte_order_strap_i,
    output logic byte_order_o,
    output ebic_pins_t pins_o,
    output logic mem_pin_oe_o,
    output logic clk_pin_oe_o
);

    // ---------------- register bus ----------------
    logic ack_ff;
    logic [31:0] dat_ff;
    logic map_ff;
    logic mem_drive_ff;
    logic clk_drive_ff;
    logic strap_s1_ff;
    logic strap_s2_ff;
    logic endian_ff;
    logic [31:0] area_q [NUM_AREAS];

    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire bus_wr = bus_req & wb_we_i;
    wire [5:0] word_idx = wb_adr_i[7:2];
    wire hit_common = (word_idx == `EBIC_IDX_COMMON);
    wire [5:0] area_idx = word_idx - `EBIC_IDX_AREA0;
    wire hit_area = (word_idx >= `EBIC_IDX_AREA0) &&
                    (area_idx < 6'(NUM_AREAS));
    wire cmn_wr = bus_wr & hit_common;
    wire [7:0] cmn_lane0 = wb_dat_i[7:0];
    wire [7:0] cmn_lane1 = wb_dat_i[15:8];

    wire [31:0] common_rd = {
        19'h0_0000,
        map_ff,
        7'h00,
        1'b1,
        endian_ff,
        1'b1,
        mem_drive_ff,
        clk_drive_ff
    };

    logic [31:0] area_rd;
    always_comb begin
        area_rd = 32'h0000_0000;
        for (int k = 0; k < NUM_AREAS; k++) begin
            if (area_idx == 6'(k)) begin
                area_rd = area_q[k];
            end
        end
    end

    // unmapped words answer with ack and zero data
    wire [31:0] nxt_dat = hit_common ? common_rd : (hit_area ? area_rd : 32'h0000_0000);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= bus_req;
            dat_ff <= bus_req ? nxt_dat : dat_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_ff <= 1'b0;
            mem_drive_ff <= 1'b0;
            clk_drive_ff <= 1'b0;
        end else begin
            if (cmn_wr && wb_sel_i[1]) begin
                map_ff <= cmn_lane1[`EBIC_CMN_MAP_BIT - 8];
            end
            if (cmn_wr && wb_sel_i[0]) begin
                mem_drive_ff <= cmn_lane0[`EBIC_CMN_MEMDRV_BIT];
                clk_drive_ff <= cmn_lane0[`EBIC_CMN_CLKDRV_BIT];
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;

    // one register per space: 0, 2, 3, 4, 5B, 6B in index order
    genvar g;
    generate
        for (g = 0; g < NUM_AREAS; g++) begin : g_area
            ebic_area_reg #(
                .RESET_VAL(`EBIC_AREA_RST)
            ) u_reg (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .wr_en_i(bus_wr && hit_area && (area_idx == 6'(g))),
                .sel_i(wb_sel_i),
                .wdat_i(wb_dat_i),
                .q_o(area_q[g])
            );
        end
    endgenerate

    // ---------------- byte-order strap ----------------
    // the flag follows the synchronised strap only while reset is held
    always_ff @(posedge clk_i) begin
        strap_s1_ff <= byte_order_strap_i;
        strap_s2_ff <= strap_s1_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            endian_ff <= strap_s2_ff;
        end
    end

    assign byte_order_o = endian_ff;

    // ---------------- idle cycle insertion ----------------
    ebic_seq_t state_ff;
    ebic_seq_t nxt_state;
    logic have_prev_ff;
    logic last_wr_ff;
    logic [2:0] last_area_ff;
    logic [2:0] gap_ff;
    logic done_ff;
    ebic_pins_t pins_ff;

    function automatic logic [2:0] ebic_decode(input logic [1:0] code);
        logic [2:0] cnt;
        cnt = `EBIC_IDLE_CODE0;
        case (code)
            2'h0: cnt = `EBIC_IDLE_CODE0;
            2'h1: cnt = `EBIC_IDLE_CODE1;
            2'h2: cnt = `EBIC_IDLE_CODE2;
            2'h3: cnt = `EBIC_IDLE_CODE3;
            default: cnt = `EBIC_IDLE_CODE3;
        endcase
        return cnt;
    endfunction : ebic_decode

    wire [31:0] last_reg = area_q[last_area_ff];
    wire [1:0] iww_code = last_reg[`EBIC_IWW_LSB +: 2];
    wire [1:0] rwd_code = last_reg[`EBIC_READ_WRITE_CROSS_AREA_IDLE_SEL_LSB +: 2];
    wire [1:0] rws_code = last_reg[`EBIC_READ_WRITE_SAME_AREA_IDLE_SEL_LSB +: 2];
    wire [2:0] iww_cnt = ebic_decode(iww_code);
    wire [2:0] rwd_cnt = ebic_decode(rwd_code);
    wire [2:0] rws_cnt = ebic_decode(rws_code);
    wire same_area = (acc_i.area == last_area_ff);
    wire area_ok = (acc_i.area < 3'(NUM_AREAS));

    logic [2:0] need;
    always_comb begin
        need = `EBIC_IDLE_CODE0;
        if (have_prev_ff && last_wr_ff) begin
            need = iww_cnt;
        end else if (have_prev_ff && acc_i.write) begin
            need = same_area ? rws_cnt : rwd_cnt;
        end
    end

    wire grant = acc_valid_i && area_ok && !standby_i && (gap_ff >= need);
    wire [2:0] nxt_gap = grant ? 3'h0 :
                         ((gap_ff == `EBIC_GAP_MAX) ? gap_ff : 3'(gap_ff + 3'h1));

    always_comb begin
        nxt_state = EBIC_SEQ_IDLE;
        case (state_ff)
            EBIC_SEQ_IDLE: nxt_state = grant ? EBIC_SEQ_ACCESS : EBIC_SEQ_IDLE;
            EBIC_SEQ_ACCESS: nxt_state = grant ? EBIC_SEQ_ACCESS : EBIC_SEQ_IDLE;
            default: nxt_state = EBIC_SEQ_IDLE;
        endcase
    end

    ebic_pins_t nxt_pins;
    always_comb begin
        nxt_pins = pins_ff;
        nxt_pins.bus_start_strobe_n = 1'b1;
        nxt_pins.area_select_n = 6'h3f;
        nxt_pins.read_strobe_n = 1'b1;
        if (grant) begin
            nxt_pins.ext_addr = acc_i.addr;
            nxt_pins.bus_start_strobe_n = 1'b0;
            nxt_pins.area_select_n = ~(6'h01 << acc_i.area);
            nxt_pins.read_write = !acc_i.write;
            nxt_pins.read_strobe_n = acc_i.write;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= EBIC_SEQ_IDLE;
            gap_ff <= `EBIC_GAP_MAX;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            gap_ff <= nxt_gap;
            done_ff <= grant;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            have_prev_ff <= 1'b0;
            last_wr_ff <= 1'b0;
            last_area_ff <= 3'h0;
        end else if (grant) begin
            have_prev_ff <= 1'b1;
            last_wr_ff <= acc_i.write;
            last_area_ff <= acc_i.area;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_ff <= '{ext_addr: 26'h000_0000, bus_start_strobe_n: 1'b1,
                         area_select_n: 6'h3f, read_write: 1'b1, read_strobe_n: 1'b1};
        end else begin
            pins_ff <= nxt_pins;
        end
    end

    assign pins_o = pins_ff;
    assign acc_done_o = done_ff;

    // ---------------- standby pin drive ----------------
    logic mem_oe_ff;
    logic clk_oe_ff;
    wire nxt_mem_oe = !standby_i || mem_drive_ff;
    wire nxt_clk_oe = !standby_i || clk_drive_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mem_oe_ff <= 1'b1;
            clk_oe_ff <= 1'b1;
        end else begin
            mem_oe_ff <= nxt_mem_oe;
            clk_oe_ff <= nxt_clk_oe;
        end
    end

    assign mem_pin_oe_o = mem_oe_ff;
    assign clk_pin_oe_o = clk_oe_ff;

    // ---------------- checks ----------------
    mem_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        standby_i && !mem_drive_ff |=> !mem_pin_oe_o)
        else $error("memory pins not floated in standby");

    mem_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mem_drive_ff && $past(mem_drive_ff) |-> mem_pin_oe_o)
        else $error("memory pins released while drive bit set");

    clk_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        standby_i && !clk_drive_ff |=> !clk_pin_oe_o ##0 !$past(clk_drive_ff))
        else $error("clock pins not floated in standby");

    strap_hold_a: assert property (@(posedge clk_i)
        !rst_i && !$past(rst_i) |-> $stable(endian_ff))
        else $error("byte-order flag changed outside reset");

    endian_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_we_i && hit_common |=> wb_ack_o && wb_dat_o[3] == byte_order_o)
        else $error("byte-order flag misread");

    write_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ff && last_wr_ff && iww_code == 2'h3 |=> !done_ff [*4])
        else $error("write-follow gap shorter than four");

    cross_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ff && !last_wr_ff && rwd_code != 2'h0 && acc_valid_i && acc_i.write &&
        !same_area |=> !done_ff)
        else $error("cross-area read-write gap too short");

    same_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_ff && !last_wr_ff && rws_code == 2'h2 ##1 grant && acc_i.write && same_area
        |-> 1'b0)
        else $error("same-area read-write gap too short");

    rsvd_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !wb_we_i && hit_area |=> wb_dat_o[31:30] == 2'h0)
        else $error("reserved area bits read nonzero");

    reset_four_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> iww_cnt == 3'h4 && rwd_cnt == 3'h4 && rws_cnt == 3'h4)
        else $error("idle fields not four after reset");

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // the access cycle must show the start strobe and exactly one area select
    strobe_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        state_ff == EBIC_SEQ_ACCESS |-> !pins_o.bus_start_strobe_n &&
        $onehot(~pins_o.area_select_n) && acc_done_o)
        else $error("access cycle without strobe and one select");

    strobe_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !acc_done_o |-> pins_o.bus_start_strobe_n && pins_o.read_strobe_n &&
        pins_o.area_select_n == 6'h3f)
        else $error("strobe active outside an access cycle");

    standby_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        standby_i |=> !acc_done_o)
        else $error("access granted in standby");

    // address and direction stay put between accesses
    addr_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !acc_done_o && !$past(rst_i) |-> $stable(pins_o.ext_addr) && $stable(pins_o.read_write))
        else $error("address or direction moved between accesses");

endmodule : ebic_ctrl

// ==== shared/ebic_params.svh ====
// register map, field positions, reset values and idle counts of the idle/standby controller
`ifndef EBIC_PARAMS_SVH
`define EBIC_PARAMS_SVH

`define EBIC_NUM_AREAS 6
`define EBIC_OFF_COMMON 8'h00
`define EBIC_OFF_AREA0 8'h04
`define EBIC_IDX_COMMON 6'h00
`define EBIC_IDX_AREA0 6'h01

`define EBIC_CMN_MAP_BIT 12
`define EBIC_CMN_ONE4_BIT 4
`define EBIC_CMN_ENDIAN_BIT 3
`define EBIC_CMN_ONE2_BIT 2
`define EBIC_CMN_MEMDRV_BIT 1
`define EBIC_CMN_CLKDRV_BIT 0

`define EBIC_AREA_WMASK 32'h36db_f7ff
`define EBIC_AREA_RST 32'h36db_0600
`define EBIC_AREA_RSVD 32'hc924_0800
`define EBIC_IWW_LSB 28
`define EBIC_READ_WRITE_CROSS_AREA_IDLE_SEL_LSB 25
`define EBIC_READ_WRITE_SAME_AREA_IDLE_SEL_LSB 22

`define EBIC_IDLE_CODE0 3'h0
`define EBIC_IDLE_CODE1 3'h1
`define EBIC_IDLE_CODE2 3'h2
`define EBIC_IDLE_CODE3 3'h4
`define EBIC_GAP_MAX 3'h7

`endif

// ==== shared/ebic_pkg.sv ====
// types shared by the idle/standby controller files
package ebic_pkg;

    typedef struct packed {
        logic write;
        logic [2:0] area;
        logic [25:0] addr;
    } ebic_acc_t;

    typedef struct packed {
        logic [25:0] ext_addr;
        logic bus_start_strobe_n;
        logic [5:0] area_select_n;
        logic read_write;
        logic read_strobe_n;
    } ebic_pins_t;

    typedef enum logic [0:0] {
        EBIC_SEQ_IDLE,
        EBIC_SEQ_ACCESS
    } ebic_seq_t;

endpackage : ebic_pkg

// ==== hw/ebic_area_reg.sv ====
// one area bus control register with byte enables and hardwired reserved bits
`timescale 1ns/1ns
`include "ebic_params.svh"
module ebic_area_reg
    import ebic_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = `EBIC_AREA_RST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] wdat_i,
    output logic [31:0] q_o
);
    logic [31:0] q_ff;
    wire [31:0] byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
    wire [31:0] wr_mask = byte_mask & `EBIC_AREA_WMASK;
    wire [31:0] nxt_q = wr_en_i ? ((q_ff & ~wr_mask) | (wdat_i & wr_mask)) : q_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_ff <= RESET_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q_o = q_ff;

    rsvd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (q_ff & `EBIC_AREA_RSVD) == 32'h0000_0000)
        else $error("reserved area bits not zero");

endmodule : ebic_area_reg

// ==== sim/ebic_mem_model.sv ====
// external memory stand-in that counts the accesses it sees on the pins
`timescale 1ns/1ns
module ebic_mem_model
    import ebic_pkg::*;
(
    input wire logic clk_i,
    input wire ebic_pins_t pins_i,
    input wire logic mem_oe_i,
    output int reads_o,
    output int writes_o
);
    int rd_cnt = 0;
    int wr_cnt = 0;
    // an access counts only while the pin group is driven
    always @(posedge clk_i) begin
        if (mem_oe_i && !pins_i.bus_start_strobe_n) begin
            if (pins_i.read_write) begin
                rd_cnt <= rd_cnt + 1;
            end else begin
                wr_cnt <= wr_cnt + 1;
            end
        end
    end
    assign reads_o = rd_cnt;
    assign writes_o = wr_cnt;
endmodule : ebic_mem_model

// ==== sim/tb.sv ====
// self-checking bench for the idle-cycle and standby controller
`timescale 1ns/1ns
`include "ebic_params.svh"
module tb
    import ebic_pkg::*;
;
    localparam ebic_acc_t WR0 = '{1'b1, 3'h0, 26'h10};
    localparam ebic_acc_t RD0 = '{1'b0, 3'h0, 26'h20};
    localparam ebic_acc_t WR1 = '{1'b1, 3'h1, 26'h30};
    logic clk_i, rst_i, cyc, stb, we, ack, strap, standby, go, second, done, bo, moe, coe;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, q, rdat;
    ebic_acc_t a1, a2, acc;
    ebic_pins_t pins;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int reads, writes, gap;
    int idle_tab [4] = '{0, 1, 2, 4};

    // the next request is shown combinationally in the done cycle
    assign acc = (done || second) ? a2 : a1;

    ebic_ctrl dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .acc_valid_i(go & ~(second & done)), .acc_i(acc), .acc_done_o(done),
        .standby_i(standby), .byte_order_strap_i(strap), .byte_order_o(bo),
        .pins_o(pins), .mem_pin_oe_o(moe), .clk_pin_oe_o(coe)
    );

    ebic_mem_model mem_u (
        .clk_i(clk_i), .pins_i(pins), .mem_oe_i(moe), .reads_o(reads), .writes_o(writes)
    );

    initial begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int c;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= d;
        c = 0;
        do begin
            @(posedge clk_i);
            c++;
        end while (ack !== 1'b1 && c < 20);
        if (ack !== 1'b1) begin
            errors++;
            $display("BAD wb ack expected 1 seen %b", ack);
        end
        q = rdat;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask : wb

    // two accesses back to back; gap gets the idle cycles between their done pulses
    task automatic pair(input ebic_acc_t x, input ebic_acc_t y, input int e);
        int c;
        a1 <= x;
        a2 <= y;
        go <= 1;
        c = 0;
        do begin
            @(negedge clk_i);
            c++;
        end while (done !== 1'b1 && c < 50);
        @(posedge clk_i);
        second <= 1;
        gap = 0;
        @(negedge clk_i);
        while (done !== 1'b1 && gap < 50) begin
            gap++;
            @(negedge clk_i);
        end
        @(posedge clk_i);
        go <= 0;
        second <= 0;
        @(posedge clk_i);
        chk("idle cycles", e, gap);
        chk("ext addr", 32'(y.addr), 32'(pins.ext_addr));
        chk("read write", 32'(!y.write), 32'(pins.read_write));
    endtask : pair

    initial begin
        rst_i = 1;
        {cyc, stb, we, go, second, standby} = '0;
        adr = '0;
        sel = 4'hf;
        dat = '0;
        strap = 1;
        a1 = '0;
        a2 = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        strap <= 0;
        @(posedge clk_i);
        wb(0, 8'h00, 0);
        chk("common", 32'h0000_001c, q);
        chk("byte order", 32'h1, {31'h0, bo});
        for (int i = 0; i < 7; i++) begin
            wb(0, 8'h04 + 8'(4 * i), 0);
            chk("area reg", (i < 6) ? `EBIC_AREA_RST : 32'h0, q);
        end
        pair(WR0, RD0, 4);
        wb(1, 8'h04, `EBIC_AREA_WMASK);
        wb(0, 8'h04, 0);
        chk("area0 mask", `EBIC_AREA_WMASK, q);
        for (int k = 0; k < 4; k++) begin
            wb(1, 8'h04, (32'(k) << 28) | 32'h0000_0600);
            pair(WR0, k[0] ? WR0 : RD0, idle_tab[k]);
        end
        wb(1, 8'h04, 32'h0280_0600);
        pair(RD0, WR0, 2);
        wb(1, 8'h08, 32'h0000_0600);
        pair(RD0, WR1, 1);
        chk("pin accesses", 32'd14, 32'(reads + writes));
        // a request held through standby must wait until standby ends
        a2 <= RD0;
        go <= 1;
        second <= 1;
        standby <= 1;
        repeat (5) @(posedge clk_i);
        chk("standby access", 32'd14, 32'(reads + writes));
        standby <= 0;
        @(posedge clk_i);
        go <= 0;
        second <= 0;
        repeat (2) @(posedge clk_i);
        chk("after standby", 32'd15, 32'(reads + writes));
        for (int j = 0; j < 4; j++) begin
            wb(1, 8'h00, 32'h0000_0014 | 32'(j));
            standby <= 1;
            repeat (3) @(posedge clk_i);
            chk("standby oe", 32'(j), {30'h0, moe, coe});
            standby <= 0;
            @(posedge clk_i);
        end
        rst_i <= 1;
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        wb(0, 8'h00, 0);
        chk("common", 32'h0000_0014, q);
        end_of_test();
    end
endmodule : tb
